// File: design/cpuasd_decoder.sv
// cpu address space decoder: fetch and operand address translation and routing
// assumes one target bus that acknowledges with tgt_ack_in and same-clock cpu inputs
//
// Behaviour
// - instruction pointer keeps 26 bits, top zero
// - operand bits 31 to 26 ignored
// - operand address sum wraps modulo 2^32
// - operand bit 25 sign-extended through bit 31
// - top 4 KB routed to peripheral registers for operands, fetch there faulted
// - low 1 MB is internal rom region
// - rom end by size, rest prohibited
// - writes into rom region go external
// - 3FF0000H to 3FFEFFFH is ram region
// - ram start by size, below prohibited
// - peripheral word split, low half first
// - byte register halfword: upper byte dropped
// - 0100000H to 0FFFFFFH goes external
// - hardwired zero gpr base reads zero
`timescale 1ns/1ps
`default_nettype none
`include "cpuasd_regs.svh"

module cpuasd_decoder
  import cpuasd_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            nrst_in,
  input  wire cpuasd_rom_cfg_t rom_cfg_in,
  input  wire logic            ram_small_in,
  input  wire logic            fetch_req_in,
  input  wire logic [31:0]     instruction_pointer_in,
  input  wire logic [31:0]     branch_disp_in,
  output logic                 fetch_valid_out,
  output logic [31:0]          fetch_addr_out,
  output cpuasd_tgt_t          fetch_tgt_out,
  output logic                 fetch_fault_out,
  input  wire logic            op_req_in,
  input  wire logic            op_write_in,
  input  wire cpuasd_size_t    op_size_in,
  input  wire logic [4:0]      op_base_idx_in,
  input  wire logic [31:0]     op_base_val_in,
  input  wire logic [15:0]     signed_offset_field_in,
  input  wire logic [31:0]     op_wdata_in,
  output logic                 op_ready_out,
  output logic                 op_done_out,
  output logic [31:0]          op_rdata_out,
  output logic [31:0]          op_addr_out,
  output cpuasd_tgt_t          op_tgt_out,
  output logic                 mem_valid_out,
  output cpuasd_mem_req_t      mem_req_out,
  input  wire logic            tgt_ack_in,
  input  wire logic [31:0]     tgt_rdata_in,
  input  wire logic            periph_byte_wide_in
);

  // region decode shared by fetch and operand paths
  function automatic cpuasd_tgt_t decode_tgt(input logic [25:0] a,
                                             input logic        wr,
                                             input logic        fetch,
                                             input logic [25:0] rom_end,
                                             input logic [25:0] ram_start);
    cpuasd_tgt_t t;
    t = CPUASD_TGT_PROHIB;
    if (a <= `CPUASD_ROM_TOP) begin
      if (wr)
        t = CPUASD_TGT_EXT;
      else if (a <= rom_end)
        t = CPUASD_TGT_ROM;
    end else if (a >= `CPUASD_EXT_BASE && a <= `CPUASD_EXT_TOP) begin
      t = CPUASD_TGT_EXT;
    end else if (a >= `CPUASD_RAM_BASE && a <= `CPUASD_RAM_TOP) begin
      if (a >= ram_start)
        t = CPUASD_TGT_RAM;
    end else if (a >= `CPUASD_PERIPH_BASE) begin
      // no fetch path exists here, so a stray branch is reported, not served
      t = fetch ? CPUASD_TGT_PROHIB : CPUASD_TGT_PERIPH;
    end
    return t;
  endfunction

  // size configuration
  wire logic [25:0] rom_end;
  wire logic [25:0] ram_start;
  assign rom_end   = (rom_cfg_in == CPUASD_ROM_128K) ? `CPUASD_ROM_END_128K :
                     (rom_cfg_in == CPUASD_ROM_96K)  ? `CPUASD_ROM_END_96K  :
                                                       `CPUASD_ROM_END_256K;
  assign ram_start = ram_small_in ? `CPUASD_RAM_START_6K : `CPUASD_RAM_START_16K;

  // fetch path: carry out of bit 25 is simply lost
  wire logic [31:0] fetch_sum;
  wire logic [25:0] fetch_phys;
  wire cpuasd_tgt_t fetch_tgt;
  assign fetch_sum  = instruction_pointer_in + branch_disp_in;
  assign fetch_phys = fetch_sum[25:0];
  assign fetch_tgt  = decode_tgt(fetch_phys, 1'b0, 1'b1, rom_end, ram_start);

  logic        fetch_valid_r;
  logic [25:0] fetch_phys_r;
  cpuasd_tgt_t fetch_tgt_r;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      fetch_valid_r <= 1'b0;
      fetch_phys_r  <= 26'h0000000;
      fetch_tgt_r   <= CPUASD_TGT_ROM;
    end else begin
      fetch_valid_r <= fetch_req_in;
      if (fetch_req_in) begin
        fetch_phys_r <= fetch_phys;
        fetch_tgt_r  <= fetch_tgt;
      end
    end
  end

  assign fetch_valid_out = fetch_valid_r;
  assign fetch_addr_out  = {6'h00, fetch_phys_r};
  assign fetch_tgt_out   = fetch_tgt_r;
  assign fetch_fault_out = fetch_valid_r && (fetch_tgt_r == CPUASD_TGT_PROHIB);

  // operand address: zero gpr as base, 32-bit wrap, upper bits dropped
  wire logic [31:0] op_base;
  wire logic [31:0] op_disp;
  wire logic [31:0] op_sum;
  wire logic [25:0] op_phys;
  wire cpuasd_tgt_t op_tgt;
  assign op_base = (op_base_idx_in == `CPUASD_ZERO_GPR_IDX) ? 32'h00000000 : op_base_val_in;
  assign op_disp = {{16{signed_offset_field_in[15]}}, signed_offset_field_in};
  assign op_sum  = op_base + op_disp;
  assign op_phys = op_sum[25:0];
  assign op_tgt  = decode_tgt(op_phys, op_write_in, 1'b0, rom_end, ram_start);

  cpuasd_state_t   state_r;
  cpuasd_state_t   state_nxt;
  logic [25:0]     cur_phys_r;
  cpuasd_tgt_t     cur_tgt_r;
  logic            cur_write_r;
  cpuasd_size_t    cur_size_r;
  logic [31:0]     cur_wdata_r;
  logic [15:0]     low_half_r;
  logic [31:0]     rdata_r;
  cpuasd_mem_req_t req_r;

  wire logic op_take;
  wire logic periph_split;
  wire logic issue_ack;
  wire logic high_ack;
  assign op_take      = op_req_in && (state_r == CPUASD_ST_IDLE);
  assign periph_split = (cur_tgt_r == CPUASD_TGT_PERIPH) && (cur_size_r == CPUASD_SZ_WORD);
  assign issue_ack    = (state_r == CPUASD_ST_ISSUE) && tgt_ack_in;
  assign high_ack     = (state_r == CPUASD_ST_HIGH) && tgt_ack_in;

  // byte-wide peripheral register: only the low byte is meaningful either way
  wire logic [15:0] periph_half;
  assign periph_half = periph_byte_wide_in ? {8'h00, tgt_rdata_in[7:0]} : tgt_rdata_in[15:0];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CPUASD_ST_IDLE:  if (op_take) state_nxt = CPUASD_ST_ISSUE;
      CPUASD_ST_ISSUE: begin
        if (cur_tgt_r == CPUASD_TGT_PROHIB)
          state_nxt = CPUASD_ST_DONE;
        else if (tgt_ack_in)
          state_nxt = periph_split ? CPUASD_ST_HIGH : CPUASD_ST_DONE;
      end
      CPUASD_ST_HIGH:  if (tgt_ack_in) state_nxt = CPUASD_ST_DONE;
      CPUASD_ST_DONE:  state_nxt = CPUASD_ST_IDLE;
      default:         state_nxt = CPUASD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r <= CPUASD_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // latch the decoded access when it is taken
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cur_phys_r  <= 26'h0000000;
      cur_tgt_r   <= CPUASD_TGT_ROM;
      cur_write_r <= 1'b0;
      cur_size_r  <= CPUASD_SZ_BYTE;
      cur_wdata_r <= `CPUASD_RST_DATA;
    end else if (op_take) begin
      cur_phys_r  <= op_phys;
      cur_tgt_r   <= op_tgt;
      cur_write_r <= op_write_in;
      cur_size_r  <= op_size_in;
      cur_wdata_r <= op_wdata_in;
    end
  end

  // target request: a peripheral word becomes two halfwords on an aligned word
  wire logic [25:0]  word_base;
  wire cpuasd_size_t first_size;
  wire logic [25:0]  first_addr;
  assign word_base  = {op_phys[25:2], 2'b00};
  assign first_size = (op_tgt == CPUASD_TGT_PERIPH && op_size_in == CPUASD_SZ_WORD) ?
                      CPUASD_SZ_HALF : op_size_in;
  assign first_addr = (op_tgt == CPUASD_TGT_PERIPH && op_size_in == CPUASD_SZ_WORD) ?
                      word_base : op_phys;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      req_r <= '0;
    end else if (op_take) begin
      req_r.tgt   <= op_tgt;
      req_r.write <= op_write_in;
      req_r.size  <= first_size;
      req_r.addr  <= first_addr;
      req_r.wdata <= op_wdata_in;
    end else if (issue_ack && periph_split) begin
      req_r.addr  <= req_r.addr + `CPUASD_HALF_STEP;
      req_r.wdata <= {16'h0000, cur_wdata_r[31:16]};
    end
  end

  // read data gathering; prohibited reads answer zero
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      low_half_r <= 16'h0000;
      rdata_r    <= `CPUASD_RST_DATA;
    end else if (op_take) begin
      rdata_r    <= `CPUASD_RST_DATA;
    end else if (issue_ack && cur_tgt_r != CPUASD_TGT_PROHIB) begin
      if (periph_split)
        low_half_r <= periph_half;
      else if (cur_tgt_r == CPUASD_TGT_PERIPH)
        rdata_r    <= {16'h0000, periph_half};
      else
        rdata_r    <= tgt_rdata_in;
    end else if (high_ack) begin
      rdata_r    <= {periph_half, low_half_r};
    end
  end

  // write data to a byte register is trimmed to its low byte here, since the
  // width answer only arrives alongside the request
  wire logic [31:0] mem_wdata;
  assign mem_wdata = (req_r.tgt == CPUASD_TGT_PERIPH && periph_byte_wide_in) ?
                     {24'h000000, req_r.wdata[7:0]} : req_r.wdata;

  wire logic issuing;
  assign issuing = ((state_r == CPUASD_ST_ISSUE) && (cur_tgt_r != CPUASD_TGT_PROHIB)) ||
                   (state_r == CPUASD_ST_HIGH);

  assign mem_valid_out = issuing;
  assign mem_req_out   = '{tgt: req_r.tgt, write: req_r.write, size: req_r.size,
                           addr: req_r.addr, wdata: mem_wdata};
  assign op_ready_out  = (state_r == CPUASD_ST_IDLE);
  assign op_done_out   = (state_r == CPUASD_ST_DONE);
  assign op_rdata_out  = rdata_r;
  assign op_addr_out   = {{6{cur_phys_r[25]}}, cur_phys_r};
  assign op_tgt_out    = cur_tgt_r;

  a_fetch_top_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    fetch_req_in |=> fetch_valid_out && fetch_addr_out[31:26] == 6'h00 &&
                     fetch_addr_out[25:0] == $past(fetch_sum[25:0]))
    else $error("fetch address not truncated to 26 bits");

  a_fetch_no_periph: assert property (@(posedge clk_in) disable iff (!nrst_in)
    fetch_valid_out && fetch_addr_out[25:12] == 14'h3FFF |-> fetch_fault_out)
    else $error("fetch into peripheral area not faulted");

  a_op_sign_ext: assert property (@(posedge clk_in) disable iff (!nrst_in)
    op_take |=> op_addr_out[31:26] == {6{$past(op_sum[25])}})
    else $error("operand address not sign extended");

  a_zero_base_wrap: assert property (@(posedge clk_in) disable iff (!nrst_in)
    op_take && op_base_idx_in == 5'h00 |=>
      op_addr_out == {{16{$past(signed_offset_field_in[15])}}, $past(signed_offset_field_in)})
    else $error("zero gpr base did not give displacement alone");

  a_op_wrap_sum: assert property (@(posedge clk_in) disable iff (!nrst_in)
    op_take |=> op_addr_out[25:0] == $past(op_base_val_in[25:0] + op_disp[25:0]) ||
                $past(op_base_idx_in) == 5'h00)
    else $error("operand address sum wrong");

  a_periph_route: assert property (@(posedge clk_in) disable iff (!nrst_in)
    mem_valid_out && mem_req_out.tgt == CPUASD_TGT_PERIPH |->
      mem_req_out.addr[25:12] == 14'h3FFF && mem_req_out.size != CPUASD_SZ_WORD)
    else $error("peripheral request outside area or full word");

  a_split_order: assert property (@(posedge clk_in) disable iff (!nrst_in)
    issue_ack && periph_split |-> mem_req_out.addr[1:0] == 2'b00 ##1
      (state_r == CPUASD_ST_HIGH && mem_req_out.addr[1:0] == 2'b10))
    else $error("peripheral word split order wrong");

  a_rom_write_ext: assert property (@(posedge clk_in) disable iff (!nrst_in)
    mem_valid_out && mem_req_out.addr <= 26'h00FFFFF |->
      (mem_req_out.write ? mem_req_out.tgt == CPUASD_TGT_EXT
                         : mem_req_out.addr <= rom_end))
    else $error("rom region access misrouted");

  a_ram_window: assert property (@(posedge clk_in) disable iff (!nrst_in)
    mem_valid_out && mem_req_out.tgt == CPUASD_TGT_RAM |->
      mem_req_out.addr >= ram_start && mem_req_out.addr <= 26'h3FFEFFF)
    else $error("ram request outside implemented ram");

  a_ext_window: assert property (@(posedge clk_in) disable iff (!nrst_in)
    mem_valid_out && mem_req_out.tgt == CPUASD_TGT_EXT && !mem_req_out.write |->
      mem_req_out.addr >= 26'h0100000 && mem_req_out.addr <= 26'h0FFFFFF)
    else $error("external read outside external area");

  a_prohib_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state_r == CPUASD_ST_ISSUE && cur_tgt_r == CPUASD_TGT_PROHIB |->
      !mem_valid_out ##1 (op_done_out && op_rdata_out == 32'h00000000))
    else $error("prohibited access reached a target or read nonzero");

  a_byte_reg_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    issue_ack && cur_tgt_r == CPUASD_TGT_PERIPH && !periph_split && periph_byte_wide_in |=>
      op_rdata_out[31:8] == 24'h000000)
    else $error("byte register read kept upper bits");

endmodule // cpuasd_decoder
`default_nettype wire

// File: design/cpuasd_pkg.sv
// types shared by the cpu address space decoder
// assumes the map constants of cpuasd_regs.svh
package cpuasd_pkg;

  typedef enum logic [2:0] {
    CPUASD_TGT_ROM    = 3'h0,
    CPUASD_TGT_RAM    = 3'h1,
    CPUASD_TGT_PERIPH = 3'h2,
    CPUASD_TGT_EXT    = 3'h3,
    CPUASD_TGT_PROHIB = 3'h4
  } cpuasd_tgt_t;

  typedef enum logic [1:0] {
    CPUASD_SZ_BYTE = 2'h0,
    CPUASD_SZ_HALF = 2'h1,
    CPUASD_SZ_WORD = 2'h2
  } cpuasd_size_t;

  typedef enum logic [1:0] {
    CPUASD_ROM_256K = 2'h0,
    CPUASD_ROM_128K = 2'h1,
    CPUASD_ROM_96K  = 2'h2
  } cpuasd_rom_cfg_t;

  typedef enum logic [1:0] {
    CPUASD_ST_IDLE  = 2'h0,
    CPUASD_ST_ISSUE = 2'h1,
    CPUASD_ST_HIGH  = 2'h3,
    CPUASD_ST_DONE  = 2'h2
  } cpuasd_state_t;

  typedef struct packed {
    cpuasd_tgt_t  tgt;
    logic         write;
    cpuasd_size_t size;
    logic [25:0]  addr;
    logic [31:0]  wdata;
  } cpuasd_mem_req_t;

endpackage

// File: design/cpuasd_regs.svh
// address map constants of the cpu address space decoder
// assumes a 26-bit physical space behind a 32-bit cpu address
`ifndef CPUASD_REGS_SVH
`define CPUASD_REGS_SVH

`define CPUASD_PHYS_W        26
`define CPUASD_PHYS_TOP      26'h3FFFFFF
`define CPUASD_ROM_BASE      26'h0000000
`define CPUASD_ROM_TOP       26'h00FFFFF
`define CPUASD_ROM_END_256K  26'h003FFFF
`define CPUASD_ROM_END_128K  26'h001FFFF
`define CPUASD_ROM_END_96K   26'h0017FFF
`define CPUASD_EXT_BASE      26'h0100000
`define CPUASD_EXT_TOP       26'h0FFFFFF
`define CPUASD_RAM_BASE      26'h3FF0000
`define CPUASD_RAM_TOP       26'h3FFEFFF
`define CPUASD_RAM_START_16K 26'h3FFB000
`define CPUASD_RAM_START_6K  26'h3FFD800
`define CPUASD_PERIPH_BASE   26'h3FFF000
`define CPUASD_PERIPH_TOP    26'h3FFFFFF
`define CPUASD_HALF_STEP     26'h0000002
`define CPUASD_ZERO_GPR_IDX  5'h00
`define CPUASD_RST_DATA      32'h00000000

`endif

// File: sim/cpuasd_tgt_model.sv
// target-side responder standing behind the decoder's memory request port
// assumes the decoder holds valid and request fields until ack
`timescale 1ns/1ps
`default_nettype none
module cpuasd_tgt_model
  import cpuasd_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            nrst_in,
  input  wire logic            slow_in,
  input  wire logic            valid_in,
  input  wire cpuasd_mem_req_t req_in,
  output logic                 ack_out,
  output logic [31:0]          rdata_out,
  output logic                 byte_wide_out,
  output logic [7:0]           n_acks_out,
  output logic [7:0]           n_wr_out,
  output cpuasd_mem_req_t      last_wr_out
);
  logic [1:0]  wait_r;
  logic [31:0] held_r;
  // upper half of the peripheral page holds the byte-wide registers
  assign byte_wide_out = req_in.addr[11];
  assign ack_out       = valid_in && (wait_r == (slow_in ? 2'h2 : 2'h0));
  // a released bus shows the inverse of the last answer, never a stable copy
  assign rdata_out     = ack_out ? {~req_in.addr[15:0], req_in.addr[15:0]} : ~held_r;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wait_r     <= 2'h0;
      held_r     <= 32'h0;
      n_acks_out <= 8'h0;
      n_wr_out   <= 8'h0;
    end else begin
      wait_r <= (ack_out || !valid_in) ? 2'h0 : wait_r + 2'h1;
      if (ack_out) begin
        held_r     <= rdata_out;
        n_acks_out <= n_acks_out + 8'h1;
      end
      if (ack_out && req_in.write) begin
        n_wr_out    <= n_wr_out + 8'h1;
        last_wr_out <= req_in;
      end
    end
  end
endmodule // cpuasd_tgt_model
`default_nettype wire

// File: sim/test_cpu_address_space_decoder.sv
// self-checking bench of the cpu address space decoder
// assumes the target responder model and one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_cpu_address_space_decoder;
  import cpuasd_pkg::*;
  logic clk_in = 1'b0, nrst = 1'b0, ram_small = 1'b0, slow = 1'b0;
  logic fetch_req = 1'b0, fetch_valid, fetch_fault, op_req = 1'b0, op_write = 1'b0;
  logic op_ready, op_done, mem_valid, ack, byte_wide;
  logic [31:0] ip = 32'h0, disp = 32'h0, op_base = 32'h0, op_wdata = 32'h0;
  logic [31:0] fetch_addr, op_rdata, op_addr, tdata;
  logic [15:0] op_off = 16'h0;
  logic [4:0]  op_idx = 5'h01;
  logic [7:0]  n_acks, n_wr;
  cpuasd_rom_cfg_t rom_cfg = CPUASD_ROM_256K;
  cpuasd_size_t    op_size = CPUASD_SZ_WORD;
  cpuasd_tgt_t     fetch_tgt, op_tgt;
  cpuasd_mem_req_t mem_req, last_wr;
  int mismatches = 0, n_checks = 0;
  always #5 clk_in = ~clk_in;
  cpuasd_decoder i_dut (.clk_in(clk_in), .nrst_in(nrst), .rom_cfg_in(rom_cfg), .ram_small_in(ram_small),
    .fetch_req_in(fetch_req), .instruction_pointer_in(ip), .branch_disp_in(disp),
    .fetch_valid_out(fetch_valid), .fetch_addr_out(fetch_addr), .fetch_tgt_out(fetch_tgt),
    .fetch_fault_out(fetch_fault), .op_req_in(op_req), .op_write_in(op_write), .op_size_in(op_size),
    .op_base_idx_in(op_idx), .op_base_val_in(op_base), .signed_offset_field_in(op_off),
    .op_wdata_in(op_wdata), .op_ready_out(op_ready), .op_done_out(op_done), .op_rdata_out(op_rdata),
    .op_addr_out(op_addr), .op_tgt_out(op_tgt), .mem_valid_out(mem_valid), .mem_req_out(mem_req),
    .tgt_ack_in(ack), .tgt_rdata_in(tdata), .periph_byte_wide_in(byte_wide));
  cpuasd_tgt_model i_tgt (.clk_in(clk_in), .nrst_in(nrst), .slow_in(slow), .valid_in(mem_valid),
    .req_in(mem_req), .ack_out(ack), .rdata_out(tdata), .byte_wide_out(byte_wide),
    .n_acks_out(n_acks), .n_wr_out(n_wr), .last_wr_out(last_wr));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] phys(input logic [31:0] b, input logic [15:0] o);
    logic [31:0] s;
    s = b + {{16{o[15]}}, o};
    return {{6{s[25]}}, s[25:0]};
  endfunction
  function automatic logic [31:0] mdata(input logic [25:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  task automatic fetch(input logic [31:0] p, input logic [31:0] d, input logic [31:0] ea,
                       input cpuasd_tgt_t et, input logic ef);
    @(posedge clk_in);
    fetch_req <= 1'b1;
    ip        <= p;
    disp      <= d;
    @(posedge clk_in);
    fetch_req <= 1'b0;
    #1;
    check({31'h0, fetch_valid}, 32'h1);
    check(fetch_addr, ea);
    check({29'h0, fetch_tgt}, {29'h0, et});
    check({31'h0, fetch_fault}, {31'h0, ef});
  endtask
  task automatic op(input logic wr, input cpuasd_size_t sz, input logic [4:0] idx,
                    input logic [31:0] b, input logic [15:0] o, input logic [31:0] wd);
    int k;
    @(posedge clk_in);
    op_req   <= 1'b1;
    op_write <= wr;
    op_size  <= sz;
    op_idx   <= idx;
    op_base  <= b;
    op_off   <= o;
    op_wdata <= wd;
    @(posedge clk_in);
    op_req <= 1'b0;
    for (k = 0; k < 20 && op_done !== 1'b1; k++) begin
      @(posedge clk_in);
      #1;
    end
    if (op_done !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
    // ready is still low in the done cycle; a new request is taken only once back in idle
    check({31'h0, op_ready}, 32'h0);
  endtask
  // one word access through a general base register, judged against the map
  task automatic dec(input cpuasd_rom_cfg_t c, input logic rs, input logic wr, input logic [31:0] b,
                     input logic [15:0] o, input cpuasd_tgt_t t);
    logic [31:0] a;
    logic [7:0]  w0;
    logic [31:0] er;
    a         = phys(b, o);
    w0        = n_acks;
    // a peripheral word comes back as two halves gathered low first
    er        = (t == CPUASD_TGT_PERIPH) ? {a[15:2], 2'b10, a[15:2], 2'b00} : mdata(a[25:0]);
    @(posedge clk_in);
    rom_cfg   <= c;
    ram_small <= rs;
    op(wr, CPUASD_SZ_WORD, 5'h01, b, o, 32'h13579BDF);
    check({29'h0, op_tgt}, {29'h0, t});
    check(op_addr, a);
    if (!wr) check(op_rdata, (t == CPUASD_TGT_PROHIB) ? 32'h0 : er);
    check({24'h0, n_acks - w0}, (t == CPUASD_TGT_PROHIB) ? 32'h0 : (t == CPUASD_TGT_PERIPH) ? 32'h2 : 32'h1);
    if (wr && t != CPUASD_TGT_PROHIB) check({6'h0, last_wr.addr}, {6'h0, a[25:0]});
  endtask
  task automatic sc_fetch();
    fetch(32'h03FFFFFC, 32'h8, 32'h4, CPUASD_TGT_ROM, 1'b0);
    fetch(32'h0, 32'hFFFFF000, 32'h03FFF000, CPUASD_TGT_PROHIB, 1'b1);
    @(posedge clk_in);
    ram_small <= 1'b0;
    fetch(32'h03FFB000, 32'h0, 32'h03FFB000, CPUASD_TGT_RAM, 1'b0);
    @(posedge clk_in);
    ram_small <= 1'b1;
    fetch(32'h03FFB000, 32'h0, 32'h03FFB000, CPUASD_TGT_PROHIB, 1'b1);
  endtask
  task automatic sc_map();
    dec(CPUASD_ROM_256K, 1'b0, 1'b0, 32'h0003FFFC, 16'h0, CPUASD_TGT_ROM);
    dec(CPUASD_ROM_256K, 1'b0, 1'b0, 32'h00040000, 16'h0, CPUASD_TGT_PROHIB);
    dec(CPUASD_ROM_128K, 1'b0, 1'b0, 32'h0001FFFC, 16'h0, CPUASD_TGT_ROM);
    dec(CPUASD_ROM_128K, 1'b0, 1'b0, 32'h00020000, 16'h0, CPUASD_TGT_PROHIB);
    dec(CPUASD_ROM_96K, 1'b0, 1'b0, 32'h00017FFC, 16'h0, CPUASD_TGT_ROM);
    dec(CPUASD_ROM_96K, 1'b0, 1'b0, 32'h00018000, 16'h0, CPUASD_TGT_PROHIB);
    dec(CPUASD_ROM_96K, 1'b0, 1'b1, 32'h00018000, 16'h0, CPUASD_TGT_EXT);
    dec(CPUASD_ROM_256K, 1'b0, 1'b0, 32'hFC100000, 16'h0, CPUASD_TGT_EXT);
    dec(CPUASD_ROM_256K, 1'b0, 1'b0, 32'h00FFFFF0, 16'h0010, CPUASD_TGT_PROHIB);
    dec(CPUASD_ROM_256K, 1'b0, 1'b0, 32'hFFFFFFFC, 16'h0004, CPUASD_TGT_ROM);
    dec(CPUASD_ROM_256K, 1'b0, 1'b0, 32'h03FFB000, 16'hFFFC, CPUASD_TGT_PROHIB);
    dec(CPUASD_ROM_256K, 1'b0, 1'b0, 32'h03FFB000, 16'h0, CPUASD_TGT_RAM);
    dec(CPUASD_ROM_256K, 1'b1, 1'b0, 32'h03FFD800, 16'hFFFC, CPUASD_TGT_PROHIB);
    dec(CPUASD_ROM_256K, 1'b1, 1'b1, 32'h03FFEFFC, 16'h0, CPUASD_TGT_RAM);
    dec(CPUASD_ROM_256K, 1'b1, 1'b0, 32'h03FFF000, 16'h0, CPUASD_TGT_PERIPH);
  endtask
  // word accesses to peripheral registers cross the target in two halves
  // the responder answers any address; an unaligned word offset and a byte-wide register are used
  task automatic sc_periph();
    logic [7:0] w0;
    slow <= 1'b1;
    op(1'b0, CPUASD_SZ_WORD, 5'h01, 32'hFFFFF000, 16'h0013, 32'h0);
    check(op_rdata, 32'hF012F010);
    w0 = n_wr;
    op(1'b1, CPUASD_SZ_WORD, 5'h01, 32'hFFFFF000, 16'h0013, 32'hA1B2C3D4);
    check({24'h0, n_wr - w0}, 32'h2);
    check({6'h0, last_wr.addr}, 32'h03FFF012);
    check({16'h0, last_wr.wdata[15:0]}, 32'h0000A1B2);
    slow <= 1'b0;
    op(1'b0, CPUASD_SZ_HALF, 5'h01, 32'hFFFFF802, 16'h0, 32'h0);
    check(op_rdata, 32'h00000002);
    op(1'b1, CPUASD_SZ_HALF, 5'h01, 32'hFFFFF802, 16'h0, 32'h1234ABCD);
    check({16'h0, last_wr.wdata[15:0]}, 32'h000000CD);
  endtask
  task automatic sc_zero_base();
    op(1'b0, CPUASD_SZ_HALF, 5'h00, 32'hDEADBEEF, 16'hF004, 32'h0);
    check(op_addr, 32'hFFFFF004);
    check({29'h0, op_tgt}, {29'h0, CPUASD_TGT_PERIPH});
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    nrst <= 1'b1;
    sc_fetch();
    sc_map();
    sc_periph();
    sc_zero_base();
    tally_and_finish();
  end
endmodule // test_cpu_address_space_decoder
`default_nettype wire
